// file: verilog/mps_consts.vh
/*
  Constants for the multiphase PWM sequencer: register map, field
  positions, reset values and timing figures.
  Assumes a 125 MHz pclk and inclusion by the sequencer module only.
*/
// How it works
// - Main rail one to four phases, aux one
// - Master trip gives one pulse, restarts ramp
// - Four phases: round-robin, quarter period apart
// - Three phases: rotate over phases one-three
// - Two phases: alternate phase one and two
// - Single phase: every pulse to phase one
// - Phase clock pulse sets that PWM output
// - Own ripple trip clears that PWM output
// - Reverse-blocking: zero crossing stops low side
// - Reverse-blocking: no master pulse before compare trip
// - Start needs supply good and on request
// - Start-up ramps reference from zero to target
// - Ramp end: output valid high, alert low
// - Request tied high: start after fixed delay
// - Code zero off, one lowest, 5 mV steps
`ifndef MPS_CONSTS_VH
`define MPS_CONSTS_VH

// ==========================================
// Register map, byte addresses
`define MPS_ADDR_CTRL 12'h000
`define MPS_ADDR_TARGET 12'h004
`define MPS_ADDR_STATUS 12'h008
`define MPS_ADDR_DECODE 12'h00c
`define MPS_ADDR_IRQ_STAT 12'h010
`define MPS_ADDR_IRQ_MASK 12'h014

// ==========================================
// Fields
`define MPS_CTRL_NPH_LO 0
`define MPS_CTRL_NPH_HI 1
`define MPS_CTRL_RB 2
`define MPS_CTRL_RESET 32'h0000_0003
`define MPS_TARGET_RESET 32'h0000_0000
`define MPS_IRQ_RAMP_DONE 0
`define MPS_IRQ_RAIL_DROP 1
`define MPS_IRQ_ZERO_CROSS 2
`define MPS_IRQ_BITS 3

// ==========================================
// Voltage code decoding, millivolts
`define MPS_MV_BASE 16'd250
`define MPS_MV_STEP 16'd5
`define MPS_CODE_OFF 8'h00
`define MPS_CODE_ONE 16'h0001

// ==========================================
// Timing
`define MPS_CLK_MHZ 125
`define MPS_POR_DLY_US 800
`define MPS_POR_DLY_CYC (`MPS_POR_DLY_US * `MPS_CLK_MHZ)
`define MPS_STEP_NS 500
`define MPS_STEP_CYC ((`MPS_STEP_NS * `MPS_CLK_MHZ) / 1000)

`endif

// file: verilog/mps_seq.v
/*
  Multiphase PWM sequencer: phase rotation, per-phase PWM set/reset,
  reverse-blocking low-side gating, soft-start and APB registers.
  Assumes comparator and supply inputs are asynchronous pins; the
  APB master runs on pclk.
*/
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "mps_consts.vh"

module mps_seq #(
  parameter integer NPH = 4,
  parameter integer POR_DLY_CYC = `MPS_POR_DLY_CYC,
  parameter integer STEP_CYC = `MPS_STEP_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire supply_ok,
  input wire regulator_on_request,
  input wire [1:0] master_trip,
  input wire [NPH:0] ripple_trip,
  input wire [NPH:0] zero_cross,
  output reg [1:0] ramp_restart,
  output reg [NPH:0] phase_clocks,
  output reg [NPH:0] pwm,
  output reg [NPH:0] low_side_drive,
  output reg [7:0] main_ref_code,
  output reg [7:0] aux_ref_code,
  output reg output_valid,
  output reg alert_n,
  output wire irq
);

  localparam integer NIN = 2 * NPH + 6;
  localparam integer AUX = NPH;
  localparam [3:0] S_OFF = 4'b0001;
  localparam [3:0] S_WAIT = 4'b0010;
  localparam [3:0] S_RAMP = 4'b0100;
  localparam [3:0] S_RUN = 4'b1000;

  // ==========================================
  // Input synchronisers
  reg [NIN-1:0] sync1;
  reg [NIN-1:0] sync2;
  reg [NIN-1:0] sync3;
  wire [NIN-1:0] raw_in;
  wire [NIN-1:0] rise;
  wire por_s;
  wire req_s;
  wire [1:0] mtrip_ev;
  wire [NPH:0] rtrip_ev;
  wire [NPH:0] zc_ev;

  assign raw_in = {zero_cross, ripple_trip, master_trip, regulator_on_request, supply_ok};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= {NIN{1'b0}};
      sync2 <= {NIN{1'b0}};
      sync3 <= {NIN{1'b0}};
    end
    else if (ce)
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // One event per rising crossing, from the second and third stages
  assign rise = sync2 & ~sync3;
  assign por_s = sync2[0];
  assign req_s = sync2[1];
  assign mtrip_ev = rise[3:2];
  assign rtrip_ev = rise[NPH+4:4];
  assign zc_ev = rise[2*NPH+5:NPH+5];

  // ==========================================
  // Registers
  reg [31:0] ctrl;
  reg [31:0] target;
  reg [`MPS_IRQ_BITS-1:0] irq_stat;
  reg [`MPS_IRQ_BITS-1:0] irq_mask;
  reg [`MPS_IRQ_BITS-1:0] irq_ev;
  reg [3:0] state;
  wire wr_en;
  wire rd_setup;
  wire mapped;
  wire [1:0] nph_sel;
  wire rb_mode;
  wire [15:0] main_mv;
  wire [15:0] aux_mv;

  assign nph_sel = ctrl[`MPS_CTRL_NPH_HI:`MPS_CTRL_NPH_LO];
  assign rb_mode = ctrl[`MPS_CTRL_RB];
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped = (paddr == `MPS_ADDR_CTRL) | (paddr == `MPS_ADDR_TARGET) |
                  (paddr == `MPS_ADDR_STATUS) | (paddr == `MPS_ADDR_DECODE) |
                  (paddr == `MPS_ADDR_IRQ_STAT) | (paddr == `MPS_ADDR_IRQ_MASK);
  // Zero wait states; unmapped addresses flag an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign irq = |(irq_stat & irq_mask);

  function [15:0] code_mv;
    input [7:0] code;
    begin
      if (code == `MPS_CODE_OFF)
        code_mv = 16'h0000;
      else
        code_mv = `MPS_MV_BASE + `MPS_MV_STEP * ({8'h00, code} - `MPS_CODE_ONE);
    end
  endfunction

  assign main_mv = code_mv(main_ref_code);
  assign aux_mv = code_mv(aux_ref_code);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `MPS_CTRL_RESET;
      target <= `MPS_TARGET_RESET;
      irq_mask <= {`MPS_IRQ_BITS{1'b0}};
      irq_stat <= {`MPS_IRQ_BITS{1'b0}};
    end
    else if (ce)
    begin
      if (wr_en && paddr == `MPS_ADDR_CTRL)
        ctrl <= {29'h0000_0000, pwdata[2:0]};
      // Each write is a new target voltage command
      if (wr_en && paddr == `MPS_ADDR_TARGET)
        target <= {16'h0000, pwdata[15:0]};
      if (wr_en && paddr == `MPS_ADDR_IRQ_MASK)
        irq_mask <= pwdata[`MPS_IRQ_BITS-1:0];
      // A new event wins over a same-cycle clear
      if (wr_en && paddr == `MPS_ADDR_IRQ_STAT)
        irq_stat <= (irq_stat & ~pwdata[`MPS_IRQ_BITS-1:0]) | irq_ev;
      else
        irq_stat <= irq_stat | irq_ev;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (ce && rd_setup)
    begin
      case (paddr)
        `MPS_ADDR_CTRL: prdata <= ctrl;
        `MPS_ADDR_TARGET: prdata <= target;
        `MPS_ADDR_STATUS: prdata <= {8'h00, aux_ref_code, main_ref_code, 2'b00,
                                     alert_n, output_valid, state};
        `MPS_ADDR_DECODE: prdata <= {aux_mv, main_mv};
        `MPS_ADDR_IRQ_STAT: prdata <= {29'h0000_0000, irq_stat};
        `MPS_ADDR_IRQ_MASK: prdata <= {29'h0000_0000, irq_mask};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // Start-up sequence
  reg [16:0] por_cnt;
  reg [15:0] step_cnt;
  reg [3:0] next_state;
  wire por_done;
  wire step_tick;
  wire refs_at_target;
  wire running;

  assign por_done = (por_cnt == POR_DLY_CYC[16:0]);
  assign step_tick = (step_cnt == STEP_CYC[15:0] - 16'd1);
  assign refs_at_target = (main_ref_code == target[7:0]) & (aux_ref_code == target[15:8]);
  assign running = (state == S_RAMP) | (state == S_RUN);

  always @*
  begin
    case (state)
      S_OFF: next_state = por_s ? S_WAIT : S_OFF;
      S_WAIT:
      begin
        if (!por_s)
          next_state = S_OFF;
        else if (por_done && req_s)
          next_state = S_RAMP;
        else
          next_state = S_WAIT;
      end
      S_RAMP:
      begin
        if (!por_s)
          next_state = S_OFF;
        else if (!req_s)
          next_state = S_WAIT;
        else if (refs_at_target)
          next_state = S_RUN;
        else
          next_state = S_RAMP;
      end
      S_RUN:
      begin
        if (!por_s)
          next_state = S_OFF;
        else if (!req_s)
          next_state = S_WAIT;
        else
          next_state = S_RUN;
      end
      default: next_state = S_OFF;
    endcase
  end

  always @*
  begin
    irq_ev = {`MPS_IRQ_BITS{1'b0}};
    irq_ev[`MPS_IRQ_RAMP_DONE] = (state == S_RAMP) & (next_state == S_RUN);
    irq_ev[`MPS_IRQ_RAIL_DROP] = running & (next_state != S_RAMP) & (next_state != S_RUN);
    irq_ev[`MPS_IRQ_ZERO_CROSS] = |(zc_ev & low_side_drive) & rb_mode;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_OFF;
      por_cnt <= 17'd0;
      step_cnt <= 16'd0;
      main_ref_code <= 8'h00;
      aux_ref_code <= 8'h00;
      output_valid <= 1'b0;
      alert_n <= 1'b1;
    end
    else if (ce)
    begin
      state <= next_state;
      // Delay counts from the supply crossing, so a tied-high request waits it out
      if (!por_s)
        por_cnt <= 17'd0;
      else if (!por_done)
        por_cnt <= por_cnt + 17'd1;
      if (!running || step_tick)
        step_cnt <= 16'd0;
      else
        step_cnt <= step_cnt + 16'd1;
      if (!running)
      begin
        main_ref_code <= 8'h00;
        aux_ref_code <= 8'h00;
      end
      else if (step_tick)
      begin
        // One code per tick limits the slew of the reference
        if (main_ref_code < target[7:0])
          main_ref_code <= main_ref_code + 8'h01;
        else if (main_ref_code > target[7:0])
          main_ref_code <= main_ref_code - 8'h01;
        if (aux_ref_code < target[15:8])
          aux_ref_code <= aux_ref_code + 8'h01;
        else if (aux_ref_code > target[15:8])
          aux_ref_code <= aux_ref_code - 8'h01;
      end
      output_valid <= (next_state == S_RUN);
      alert_n <= ~(next_state == S_RUN);
    end
  end

  // ==========================================
  // Master pulse and phase rotation
  reg [1:0] ptr;
  reg [1:0] last_nph;
  reg [1:0] armed;
  wire [1:0] master_ok;
  wire main_rip;

  assign main_rip = |rtrip_ev[NPH-1:0];
  // Reverse-blocking holds the next pulse until a compare trip
  assign master_ok = {mtrip_ev[1] & running & (~rb_mode | armed[1]),
                      mtrip_ev[0] & running & (~rb_mode | armed[0])};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr <= 2'd0;
      last_nph <= 2'd0;
      armed <= 2'b11;
      ramp_restart <= 2'b00;
      phase_clocks <= {(NPH+1){1'b0}};
    end
    else if (ce)
    begin
      last_nph <= nph_sel;
      ramp_restart <= master_ok;
      phase_clocks <= {(NPH+1){1'b0}};
      // Trip re-arms even when it lands with a pulse
      armed[0] <= main_rip | (armed[0] & ~master_ok[0]);
      armed[1] <= rtrip_ev[AUX] | (armed[1] & ~master_ok[1]);
      if (!running || last_nph != nph_sel)
        ptr <= 2'd0;
      else if (master_ok[0])
      begin
        phase_clocks[ptr] <= 1'b1;
        if (ptr == nph_sel)
          ptr <= 2'd0;
        else
          ptr <= ptr + 2'd1;
      end
      if (master_ok[1])
        phase_clocks[AUX] <= 1'b1;
    end
  end

  // ==========================================
  // Per-phase PWM and low-side gating
  genvar g;
  generate
    for (g = 0; g <= NPH; g = g + 1)
    begin : g_phase
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pwm[g] <= 1'b0;
          low_side_drive[g] <= 1'b0;
        end
        else if (ce)
        begin
          if (!running)
          begin
            pwm[g] <= 1'b0;
            low_side_drive[g] <= 1'b0;
          end
          else if (phase_clocks[g])
          begin
            pwm[g] <= 1'b1;
            low_side_drive[g] <= 1'b0;
          end
          else if (pwm[g] && rtrip_ev[g])
          begin
            pwm[g] <= 1'b0;
            low_side_drive[g] <= 1'b1;
          end
          else if (rb_mode && zc_ev[g])
            low_side_drive[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // mps_seq

// file: verif/mps_seq_sva.sv
/* Checker for the sequencer outputs.
   Assumes it is bound to mps_seq and sees its ports only. */
`timescale 1ns/1ps
module mps_seq_sva #(
  parameter integer NPH = 4
) (
  input wire pclk,
  input wire presetn,
  input wire supply_ok,
  input wire regulator_on_request,
  input wire [NPH:0] ripple_trip,
  input wire [1:0] ramp_restart,
  input wire [NPH:0] phase_clocks,
  input wire [NPH:0] pwm,
  input wire [7:0] main_ref_code,
  input wire output_valid,
  input wire alert_n
);
  // ==========================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  clk_restart_a: assert property (|phase_clocks[NPH-1:0] |-> ramp_restart[0])
    else $error("phase clock without ramp restart");
  one_phase_a: assert property ($onehot0(phase_clocks[NPH-1:0]))
    else $error("two phase clocks at once");
  pwm_set_a: assert property (phase_clocks[0] |=> pwm[0])
    else $error("phase clock did not set pwm");
  pwm_rise_a: assert property ($rose(pwm[1]) |-> $past(phase_clocks[1]))
    else $error("pwm rose without phase clock");
  pwm_clear_a: assert property ($rose(ripple_trip[0]) |-> ##[1:6] !pwm[0])
    else $error("ripple trip did not clear pwm");
  valid_alert_a: assert property (output_valid |-> !alert_n)
    else $error("output valid with alert high");
  ref_step_a: assert property (!output_valid && $changed(main_ref_code) &&
    main_ref_code != 8'h00 |-> main_ref_code == $past(main_ref_code) + 8'h01)
    else $error("reference jumped");
  start_gate_a: assert property ($rose(output_valid) |->
    $past(supply_ok, 3) && $past(regulator_on_request, 3))
    else $error("started without supply and request");
  one_shot_a: assert property (ramp_restart[0] |=> !ramp_restart[0])
    else $error("restart pulse too long");
endmodule // mps_seq_sva

bind mps_seq mps_seq_sva #(.NPH(NPH)) u_sva (
  .pclk(pclk),
  .presetn(presetn),
  .supply_ok(supply_ok),
  .regulator_on_request(regulator_on_request),
  .ripple_trip(ripple_trip),
  .ramp_restart(ramp_restart),
  .phase_clocks(phase_clocks),
  .pwm(pwm),
  .main_ref_code(main_ref_code),
  .output_valid(output_valid),
  .alert_n(alert_n)
);

// file: verif/mps_stage.sv
/* Power stage and comparator model for five phases.
   Assumes pwm and low side drive come from the sequencer on pclk. */
`timescale 1ns/1ps
module mps_stage (
  input wire pclk,
  input wire stall,
  input wire [4:0] pwm,
  input wire [4:0] low_side_drive,
  output logic [4:0] ripple_trip = 5'h00,
  output logic [4:0] zero_cross = 5'h00
);
  // ==========================================
  // Ramps as on-time counters; stall holds a phase on
  int on_cnt [5];
  int off_cnt [5];
  always @(posedge pclk)
  begin
    for (int i = 0; i < 5; i++)
    begin
      on_cnt[i] <= pwm[i] ? on_cnt[i] + 1 : 0;
      off_cnt[i] <= low_side_drive[i] ? off_cnt[i] + 1 : 0;
      ripple_trip[i] <= pwm[i] && on_cnt[i] >= 3 && !stall;
      zero_cross[i] <= low_side_drive[i] && off_cnt[i] >= 4;
    end
  end
endmodule // mps_stage

// file: verif/mps_seq_bench.sv
/* Self-checking bench for the sequencer.
   Assumes shortened start-up counts and a zero-wait APB slave. */
`timescale 1ns/1ps
module mps_seq_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic supply_ok = 1'b0;
  logic regulator_on_request = 1'b0;
  logic stall = 1'b0;
  logic [1:0] master_trip = 2'h0;
  wire pready, pslverr, irq, output_valid, alert_n;
  wire [31:0] prdata;
  wire [4:0] ripple_trip, zero_cross, phase_clocks, pwm, low_side_drive;
  wire [1:0] ramp_restart;
  wire [7:0] main_ref_code, aux_ref_code;
  int miscompares = 0;
  int checked = 0;
  int n;
  logic [31:0] rd;
  logic err;

  initial forever #4 pclk = ~pclk;

  mps_seq #(.NPH(4), .POR_DLY_CYC(20), .STEP_CYC(2)) u_dut (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .supply_ok(supply_ok), .regulator_on_request(regulator_on_request),
    .master_trip(master_trip), .ripple_trip(ripple_trip), .zero_cross(zero_cross),
    .ramp_restart(ramp_restart), .phase_clocks(phase_clocks), .pwm(pwm),
    .low_side_drive(low_side_drive), .main_ref_code(main_ref_code),
    .aux_ref_code(aux_ref_code), .output_valid(output_valid), .alert_n(alert_n), .irq(irq));
  mps_stage u_stage (.pclk(pclk), .stall(stall), .pwm(pwm),
    .low_side_drive(low_side_drive), .ripple_trip(ripple_trip), .zero_cross(zero_cross));

  // ==========================================
  // Tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Window covers sync, edge detect and the pulse; zero means refused
  task fire(input int b, input logic [4:0] exp);
    logic [4:0] got;
    got = 5'h00;
    @(posedge pclk);
    master_trip[b] <= 1'b1;
    repeat (8)
    begin
      @(negedge pclk);
      got = got | phase_clocks;
    end
    @(posedge pclk);
    master_trip[b] <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("phase clocks", {27'h0, exp}, {27'h0, got});
  endtask

  task finish_test;
    $display("Comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    finish_test;
  end

  // ==========================================
  // Tests
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    regulator_on_request <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h3, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("decode", 32'h0, rd);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 12'h004, 32'h0000_0201);
    supply_ok <= 1'b1;
    n = 0;
    while (output_valid !== 1'b1 && n < 300)
    begin
      @(negedge pclk);
      n++;
    end
    chk("start delay", 32'h1, {31'h0, n >= 20});
    chk("output valid", 32'h1, {31'h0, output_valid});
    chk("main ref", 32'h01, {24'h0, main_ref_code});
    chk("aux ref", 32'h02, {24'h0, aux_ref_code});
    chk("alert", 32'h0, {31'h0, alert_n});
    apb(1'b0, 12'h00c, 32'h0);
    chk("decode", 32'h00ff_00fa, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("status", 32'h0002_0118, rd);
    for (n = 4; n > 0; n--)
    begin
      apb(1'b1, 12'h000, 32'(n - 1));
      for (int k = 0; k <= 2 * n; k++)
        fire(0, 5'(5'h01 << (k % n)));
    end
    fire(1, 5'h10);
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b1, 12'h000, 32'h7);
    stall <= 1'b1;
    fire(0, 5'h01);
    fire(0, 5'h00);
    stall <= 1'b0;
    repeat (30) @(negedge pclk);
    chk("low side", 32'h0, {31'h0, low_side_drive[0]});
    fire(0, 5'h02);
    repeat (30) @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0);
    chk("irq stat", 32'h5, rd);
    @(negedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h014, 32'h4);
    @(negedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h010, 32'h7);
    apb(1'b0, 12'h010, 32'h0);
    chk("irq clear", 32'h0, rd);
    // Dropping the request returns the pointer from phase three to phase one
    regulator_on_request <= 1'b0;
    repeat (10) @(negedge pclk);
    chk("valid off", 32'h0, {31'h0, output_valid});
    chk("alert off", 32'h1, {31'h0, alert_n});
    chk("main ref off", 32'h0, {24'h0, main_ref_code});
    apb(1'b0, 12'h010, 32'h0);
    chk("rail drop", 32'h2, rd);
    regulator_on_request <= 1'b1;
    repeat (20) @(negedge pclk);
    chk("restart valid", 32'h1, {31'h0, output_valid});
    chk("restart ref", 32'h01, {24'h0, main_ref_code});
    fire(0, 5'h01);
    finish_test;
  end
endmodule // mps_seq_bench
